// File: design/auto_reload_timer_with_capture.sv
// Purpose: 16-bit or dual 8-bit auto-reload timer with period capture.
// Assumes: APB master per AMBA; slow inputs asynchronous to i_clk.
// Notes: Zero-wait-state-plus-one APB answer; o_irq is a level request.

`timescale 1ns/1ps

module auto_reload_timer_with_capture
	import tmr_pkg::*;
#(
	parameter int SYS_DIV = SYS_DIV_DEFAULT,
	parameter int RTC_DIV = RTC_DIV_DEFAULT
)
(
	// Clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_rst_n,
	// APB slave
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [7:0]  i_paddr,
	input  wire logic [31:0] i_pwdata,
	output logic [31:0]      o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	// Slow count sources
	input  wire logic        i_rtc_clk,
	input  wire logic        i_cmp_out,
	// Interrupt request
	output logic             o_irq
);

	generate
		if (SYS_DIV < 2 || SYS_DIV > 16)
		begin : g_bad_sys
			$error("SYS_DIV must be 2 to 16");
		end
		if (RTC_DIV < 2 || RTC_DIV > 16)
		begin : g_bad_rtc
			$error("RTC_DIV must be 2 to 16");
		end
	endgenerate

	localparam logic [3:0] SYS_LAST = 4'(SYS_DIV - 1);
	localparam logic [3:0] RTC_LAST = 4'(RTC_DIV - 1);

	// Registers
	logic [7:0]  timer_control_reg;
	logic [1:0]  clock_control_reg;
	logic        timer_irq_enable_reg;
	logic [7:0]  count_low_byte_reg;
	logic [7:0]  count_high_byte_reg;
	logic [7:0]  reload_low_byte_reg;
	logic [7:0]  reload_high_byte_reg;

	// Bus state
	logic [31:0] prdata_reg;
	logic        pready_reg;
	logic        pslverr_reg;
	logic        irq_reg;

	// Synchronisers and tick generation
	logic [2:0]  rtc_sync_reg;
	logic [2:0]  cmp_sync_reg;
	logic [3:0]  sys_div_reg;
	logic [3:0]  rtc_div_reg;

	// Decoded bus strobes
	logic        setup;
	logic        wr_strobe;
	logic        addr_ok;
	logic [31:0] rd_value;

	// Control fields
	logic        split_mode_sel;
	logic        run_control;
	logic        capture_enable;
	logic        low_byte_irq_en;
	logic [1:0]  external_clk_sel;
	logic        capture_source_sel;
	logic        high_half_clk_sel;
	logic        low_half_clk_sel;

	// Ticks and events
	logic        div12_tick;
	logic        rtc_rise;
	logic        rtc8_tick;
	logic        cmp_rise;
	logic        low_tick;
	logic        high_tick;
	logic        low_adv;
	logic        high_adv;
	logic        low_wrap;
	logic        high_wrap;
	logic        capture_evt;
	logic        hi_flag_set;
	logic        lo_flag_set;

	assign split_mode_sel     = timer_control_reg[CTRL_SPLIT];
	assign run_control        = timer_control_reg[CTRL_RUN];
	assign capture_enable     = timer_control_reg[CTRL_CAPTURE];
	assign low_byte_irq_en    = timer_control_reg[CTRL_LO_IRQEN];
	assign external_clk_sel   = timer_control_reg[CTRL_XSEL_HI:CTRL_XSEL_LO];
	assign capture_source_sel = timer_control_reg[CTRL_XSEL_HI];
	assign high_half_clk_sel  = clock_control_reg[CLK_HIGH_SEL];
	assign low_half_clk_sel   = clock_control_reg[CLK_LOW_SEL];

	// Picks the tick for one half from its select bit and the shared field
	function automatic logic pick_tick(
		input logic       sys_sel,
		input logic [1:0] xsel,
		input logic       t_div12,
		input logic       t_rtc8,
		input logic       t_cmp
	);
		logic t;
		t = 1'b0;
		if (sys_sel)
			t = 1'b1;
		else
		begin
			case (xsel)
				XSEL_DIV12: t = t_div12;
				XSEL_RTC8:  t = t_rtc8;
				XSEL_CMP:   t = t_cmp;
				default:    t = 1'b0;
			endcase
		end
		return t;
	endfunction : pick_tick

	// Only the second and third stages are read; the first is metastable
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			rtc_sync_reg <= 3'h0;
			cmp_sync_reg <= 3'h0;
		end
		else
		begin
			rtc_sync_reg <= {rtc_sync_reg[1:0], i_rtc_clk};
			cmp_sync_reg <= {cmp_sync_reg[1:0], i_cmp_out};
		end
	end

	assign rtc_rise = rtc_sync_reg[1] & ~rtc_sync_reg[2];
	assign cmp_rise = cmp_sync_reg[1] & ~cmp_sync_reg[2];

	// System clock prescaler, free running
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			sys_div_reg <= 4'h0;
		else if (sys_div_reg == SYS_LAST)
			sys_div_reg <= 4'h0;
		else
			sys_div_reg <= sys_div_reg + 4'h1;
	end

	assign div12_tick = (sys_div_reg == SYS_LAST);

	// Slow clock divider, advanced by synchronised rising edges
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			rtc_div_reg <= 4'h0;
		else if (rtc_rise)
		begin
			if (rtc_div_reg == RTC_LAST)
				rtc_div_reg <= 4'h0;
			else
				rtc_div_reg <= rtc_div_reg + 4'h1;
		end
	end

	assign rtc8_tick = rtc_rise && (rtc_div_reg == RTC_LAST);

	assign low_tick  = pick_tick(low_half_clk_sel, external_clk_sel,
		div12_tick, rtc8_tick, cmp_rise);
	assign high_tick = pick_tick(high_half_clk_sel, external_clk_sel,
		div12_tick, rtc8_tick, cmp_rise);

	// In 16-bit mode the low half's clock drives the whole counter
	always_comb
	begin
		if (split_mode_sel)
		begin
			low_adv  = low_tick;
			high_adv = run_control && high_tick;
			low_wrap  = low_adv && (count_low_byte_reg == BYTE_MAX);
			high_wrap = high_adv && (count_high_byte_reg == BYTE_MAX);
		end
		else
		begin
			low_adv  = run_control && low_tick;
			low_wrap = low_adv && (count_low_byte_reg == BYTE_MAX);
			high_adv = low_wrap;
			high_wrap = low_wrap && (count_high_byte_reg == BYTE_MAX);
		end
	end

	assign capture_evt = capture_enable &&
		(capture_source_sel ? cmp_rise : rtc8_tick);
	assign hi_flag_set = high_wrap || capture_evt;
	assign lo_flag_set = low_wrap;

	// APB decode; the answer comes one cycle after setup
	assign setup     = i_psel && !i_penable && !pready_reg;
	assign wr_strobe = i_psel && i_penable && pready_reg && i_pwrite;

	always_comb
	begin
		addr_ok  = 1'b1;
		rd_value = 32'h0;
		case (i_paddr)
			ADDR_CTRL:      rd_value[7:0] = timer_control_reg;
			ADDR_CLK_CTRL:  rd_value[1:0] = clock_control_reg;
			ADDR_IRQ_EN:    rd_value[IRQ_EN_BIT] = timer_irq_enable_reg;
			ADDR_COUNT_LO:  rd_value[7:0] = count_low_byte_reg;
			ADDR_COUNT_HI:  rd_value[7:0] = count_high_byte_reg;
			ADDR_RELOAD_LO: rd_value[7:0] = reload_low_byte_reg;
			ADDR_RELOAD_HI: rd_value[7:0] = reload_high_byte_reg;
			default:        addr_ok = 1'b0;
		endcase
	end

	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg  <= 32'h0;
		end
		else
		begin
			pready_reg  <= setup;
			pslverr_reg <= setup && !addr_ok;
			if (setup && !i_pwrite)
				prdata_reg <= rd_value;
			else if (!setup)
				prdata_reg <= 32'h0;
		end
	end

	// Flags: a hardware set in the same cycle beats a software clear
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			timer_control_reg <= CTRL_RESET;
		else
		begin
			if (wr_strobe && i_paddr == ADDR_CTRL)
				timer_control_reg <= i_pwdata[7:0];
			if (hi_flag_set)
				timer_control_reg[CTRL_HI_FLAG] <= 1'b1;
			if (lo_flag_set)
				timer_control_reg[CTRL_LO_FLAG] <= 1'b1;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			clock_control_reg    <= CLK_RESET;
			timer_irq_enable_reg <= 1'b0;
		end
		else if (wr_strobe)
		begin
			if (i_paddr == ADDR_CLK_CTRL)
				clock_control_reg <= i_pwdata[1:0];
			if (i_paddr == ADDR_IRQ_EN)
				timer_irq_enable_reg <= i_pwdata[IRQ_EN_BIT];
		end
	end

	// Low counter half; a software write takes priority over counting
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			count_low_byte_reg <= BYTE_RESET;
		else if (wr_strobe && i_paddr == ADDR_COUNT_LO)
			count_low_byte_reg <= i_pwdata[7:0];
		else if (split_mode_sel && low_wrap)
			count_low_byte_reg <= reload_low_byte_reg;
		else if (!split_mode_sel && high_wrap)
			count_low_byte_reg <= reload_low_byte_reg;
		else if (low_adv)
			count_low_byte_reg <= count_low_byte_reg + 8'h01;
	end

	// High counter half
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			count_high_byte_reg <= BYTE_RESET;
		else if (wr_strobe && i_paddr == ADDR_COUNT_HI)
			count_high_byte_reg <= i_pwdata[7:0];
		else if (high_wrap)
			count_high_byte_reg <= reload_high_byte_reg;
		else if (high_adv)
			count_high_byte_reg <= count_high_byte_reg + 8'h01;
	end

	// Reload pair; a capture overwrites it unless software writes it then
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			reload_low_byte_reg  <= BYTE_RESET;
			reload_high_byte_reg <= BYTE_RESET;
		end
		else
		begin
			if (wr_strobe && i_paddr == ADDR_RELOAD_LO)
				reload_low_byte_reg <= i_pwdata[7:0];
			else if (capture_evt)
				reload_low_byte_reg <= count_low_byte_reg;
			if (wr_strobe && i_paddr == ADDR_RELOAD_HI)
				reload_high_byte_reg <= i_pwdata[7:0];
			else if (capture_evt)
				reload_high_byte_reg <= count_high_byte_reg;
		end
	end

	// Level request follows the sticky flags, so no overflow is missed
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			irq_reg <= 1'b0;
		else
			irq_reg <= timer_irq_enable_reg &&
				(timer_control_reg[CTRL_HI_FLAG] ||
				(low_byte_irq_en && timer_control_reg[CTRL_LO_FLAG]));
	end

	assign o_prdata  = prdata_reg;
	assign o_pready  = pready_reg;
	assign o_pslverr = pslverr_reg;
	assign o_irq     = irq_reg;

endmodule : auto_reload_timer_with_capture

// File: design/tmr_pkg.sv
// Purpose: Constants for the auto-reload timer with capture.
// Assumes: APB slave, 32-bit data, one aligned word per register.
// Notes: Offsets are byte addresses.
//
// Notes on behaviour
// - Counter is 16 bits, low and high bytes each readable and writable.
// - Control bit 3 picks one 16-bit timer (0) or two 8-bit timers (1).
// - Slow clock and comparator inputs are synchronised before they count.
// - 16-bit wrap from ffff loads the reload pair and sets high flag.
// - 16-bit mode: full overflow requests interrupt when timer irq enabled.
// - 16-bit mode: low byte wrap also interrupts when low irq enabled.
// - Split mode: each half counts and reloads from its own reload byte.
// - Split mode: run bit gates only high half; low half always counts.
// - High half clock: select bit 1 system clock, else external select.
// - Low half has own clock select, same shared external encoding.
// - Split mode: high wrap sets high flag, low wrap sets low flag.
// - Split mode: interrupt on high overflow, either half if low enabled.
// - Flags are cleared only by software, never by hardware.
// - Capture mode is active exactly while control bit 4 is one.
// - Capture event: upper select 0 every 8 slow clocks, 1 comparator rise.
// - Capture copies counter into reload pair, sets high flag, may interrupt.
// - Low flag set on every low byte wrap, in every mode.

package tmr_pkg;

	localparam logic [7:0] ADDR_CTRL      = 8'h00;
	localparam logic [7:0] ADDR_CLK_CTRL  = 8'h04;
	localparam logic [7:0] ADDR_IRQ_EN    = 8'h08;
	localparam logic [7:0] ADDR_COUNT_LO  = 8'h0c;
	localparam logic [7:0] ADDR_COUNT_HI  = 8'h10;
	localparam logic [7:0] ADDR_RELOAD_LO = 8'h14;
	localparam logic [7:0] ADDR_RELOAD_HI = 8'h18;

	localparam int CTRL_HI_FLAG  = 7;
	localparam int CTRL_LO_FLAG  = 6;
	localparam int CTRL_LO_IRQEN = 5;
	localparam int CTRL_CAPTURE  = 4;
	localparam int CTRL_SPLIT    = 3;
	localparam int CTRL_RUN      = 2;
	localparam int CTRL_XSEL_HI  = 1;
	localparam int CTRL_XSEL_LO  = 0;

	localparam int CLK_LOW_SEL   = 0;
	localparam int CLK_HIGH_SEL  = 1;
	localparam int IRQ_EN_BIT    = 0;

	localparam logic [7:0] CTRL_RESET  = 8'h00;
	localparam logic [1:0] CLK_RESET   = 2'h0;
	localparam logic [7:0] BYTE_RESET  = 8'h00;
	localparam logic [7:0] BYTE_MAX    = 8'hff;

	localparam logic [1:0] XSEL_DIV12 = 2'h0;
	localparam logic [1:0] XSEL_RTC8  = 2'h1;
	localparam logic [1:0] XSEL_RSVD  = 2'h2;
	localparam logic [1:0] XSEL_CMP   = 2'h3;

	localparam int SYS_DIV_DEFAULT = 12;
	localparam int RTC_DIV_DEFAULT = 8;

endpackage : tmr_pkg

// File: dv/auto_reload_timer_with_capture_properties.sv
// Purpose: Port checks for the timer APB slave and interrupt
// Assumes: One clock, reset asynchronous and active low
// Notes: Sees only the top module ports
`timescale 1ns/1ps
module timer_port_checker
	import tmr_pkg::*;
(
	input wire logic        i_clk,
	input wire logic        i_rst_n,
	input wire logic        i_psel,
	input wire logic        i_penable,
	input wire logic        i_pwrite,
	input wire logic [7:0]  i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic [31:0] o_prdata,
	input wire logic        o_pready,
	input wire logic        o_pslverr,
	input wire logic        o_irq
);
	wire logic mapped;
	assign mapped = (i_paddr <= ADDR_RELOAD_HI) && (i_paddr[1:0] == 2'h0);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	sequence setup_s;
		i_psel && !i_penable;
	endsequence
	sequence wr_done_s;
		i_psel && i_penable && o_pready && i_pwrite;
	endsequence
	ready_after_setup_a: assert property (setup_s |=> o_pready)
		else $error("no ready one cycle after setup");
	ready_in_access_a: assert property (o_pready |-> i_psel && i_penable)
		else $error("ready outside an access");
	err_unmapped_a: assert property (setup_s ##0 !mapped |=> o_pslverr)
		else $error("unmapped address not refused");
	err_mapped_a: assert property (setup_s ##0 mapped |=> !o_pslverr)
		else $error("mapped address refused");
	data_idle_zero_a: assert property (!o_pready |-> o_prdata == 32'h0)
		else $error("read data outside an answer");
	upper_bits_zero_a: assert property (o_pready |-> o_prdata[31:8] == 24'h0)
		else $error("upper read bits not zero");
	irq_disable_a: assert property (wr_done_s ##0
		(i_paddr == ADDR_IRQ_EN && !i_pwdata[0]) |-> ##2 !o_irq)
		else $error("interrupt stays after disable");
	irq_sticky_a: assert property ($fell(o_irq) |->
		$past(i_psel && i_penable && o_pready && i_pwrite, 2))
		else $error("interrupt dropped without a write");
endmodule : timer_port_checker

bind auto_reload_timer_with_capture timer_port_checker i_chk (.i_clk,
	.i_rst_n, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
	.o_prdata, .o_pready, .o_pslverr, .o_irq);

// File: dv/tb_auto_reload_timer_with_capture.sv
// Purpose: Self-checking bench for the auto-reload timer
// Assumes: APB answer after setup, level interrupt from sticky flags
// Notes: Reset reads and register rows first, then overflow, split and capture cases
`timescale 1ns/1ps
module tb_auto_reload_timer_with_capture;
	import tmr_pkg::*;
	typedef struct {logic [7:0] a; logic [7:0] w; logic [7:0] r; logic e;} row_s;
	logic        i_clk = 1'h0, i_rst_n = 1'h0, i_psel = 1'h0;
	logic        i_penable = 1'h0, i_pwrite = 1'h0;
	logic        i_rtc_clk = 1'h0, i_cmp_out = 1'h0;
	logic [7:0]  i_paddr = 8'h00;
	logic [31:0] i_pwdata = 32'h0, o_prdata, rd;
	logic        o_pready, o_pslverr, o_irq, err;
	logic [7:0]  first_cap;
	int          errors = 0, checks_done = 0, cycles = 0;
	row_s        rows [9] = '{'{ADDR_CTRL, 8'h23, 8'h23, 1'h0},
		'{ADDR_CLK_CTRL, 8'h03, 8'h03, 1'h0}, '{ADDR_IRQ_EN, 8'h01, 8'h01, 1'h0},
		'{ADDR_COUNT_LO, 8'ha5, 8'ha5, 1'h0}, '{ADDR_COUNT_HI, 8'h5a, 8'h5a, 1'h0},
		'{ADDR_RELOAD_LO, 8'h3c, 8'h3c, 1'h0},
		'{ADDR_RELOAD_HI, 8'hc3, 8'hc3, 1'h0},
		'{8'h1c, 8'hff, 8'h00, 1'h1}, '{8'h02, 8'hff, 8'h00, 1'h1}};

	auto_reload_timer_with_capture i_dut (.i_clk, .i_rst_n, .i_psel,
		.i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready,
		.o_pslverr, .i_rtc_clk, .i_cmp_out, .o_irq);

	always #4 i_clk = ~i_clk;

	task automatic give_verdict();
		$display("errors %0d, checks %0d", errors, checks_done);
		if (errors == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : give_verdict

	// Timeout well above the several hundred cycles the cases need
	always @(posedge i_clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			errors++;
			give_verdict();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		checks_done++;
		if (seen !== want)
		begin
			errors++;
			$display("wrong value at %0t: saw %h want %h", $time, seen, want);
		end
	endtask : check

	// Waits an edge first so the strobe is never driven twice in one step
	task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk);
		i_psel    <= 1'h1;
		i_penable <= 1'h0;
		i_pwrite  <= w;
		i_paddr   <= a;
		i_pwdata  <= {24'h0, d};
		@(posedge i_clk);
		i_penable <= 1'h1;
		// Answer is taken at the rising edge that samples pready high
		do @(posedge i_clk); while (o_pready !== 1'h1);
		rd  = o_prdata;
		err = o_pslverr;
		i_psel    <= 1'h0;
		i_penable <= 1'h0;
	endtask : apb

	task automatic rdchk(input logic [7:0] a, input logic [7:0] want);
		apb(1'h0, a, 8'h00);
		check(rd, {24'h0, want});
	endtask : rdchk

	task automatic irqchk(input logic want);
		@(negedge i_clk);
		check({31'h0, o_irq}, {31'h0, want});
	endtask : irqchk

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'h1, a, d);
	endtask : wr

	initial
	begin
		repeat (6) @(posedge i_clk);
		i_rst_n <= 1'h1;
		for (int a = 0; a <= 24; a += 4)
			rdchk(8'(a), 8'h00);
		foreach (rows[i])
		begin
			wr(rows[i].a, rows[i].w);
			check({31'h0, err}, {31'h0, rows[i].e});
			rdchk(rows[i].a, rows[i].r);
		end
		wr(ADDR_RELOAD_HI, 8'h12);
		wr(ADDR_RELOAD_LO, 8'h34);
		wr(ADDR_COUNT_HI, 8'hff);
		wr(ADDR_COUNT_LO, 8'hf0);
		wr(ADDR_CTRL, 8'h04);
		repeat (30) @(posedge i_clk);
		rdchk(ADDR_CTRL, 8'hc4);
		rdchk(ADDR_COUNT_HI, 8'h12);
		irqchk(1'h1);
		wr(ADDR_CTRL, 8'h00);
		repeat (2) @(posedge i_clk);
		irqchk(1'h0);
		wr(ADDR_COUNT_HI, 8'h00);
		wr(ADDR_COUNT_LO, 8'hfc);
		wr(ADDR_CTRL, 8'h24);
		repeat (20) @(posedge i_clk);
		irqchk(1'h1);
		rdchk(ADDR_CTRL, 8'h64);
		wr(ADDR_CTRL, 8'h00);
		wr(ADDR_COUNT_HI, 8'h77);
		wr(ADDR_COUNT_LO, 8'hf0);
		wr(ADDR_RELOAD_LO, 8'h80);
		wr(ADDR_CTRL, 8'h08);
		repeat (40) @(posedge i_clk);
		rdchk(ADDR_CTRL, 8'h48);
		rdchk(ADDR_COUNT_HI, 8'h77);
		irqchk(1'h0);
		wr(ADDR_CTRL, 8'h28);
		repeat (140) @(posedge i_clk);
		irqchk(1'h1);
		apb(1'h0, ADDR_COUNT_LO, 8'h00);
		check(rd & 32'h80, 32'h80);
		wr(ADDR_CTRL, 8'h00);
		wr(ADDR_COUNT_HI, 8'hab);
		wr(ADDR_COUNT_LO, 8'hcd);
		wr(ADDR_CTRL, 8'h13);
		i_cmp_out <= 1'h1;
		repeat (4) @(posedge i_clk);
		i_cmp_out <= 1'h0;
		repeat (6) @(posedge i_clk);
		rdchk(ADDR_RELOAD_HI, 8'hab);
		rdchk(ADDR_RELOAD_LO, 8'hcd);
		rdchk(ADDR_CTRL, 8'h93);
		wr(ADDR_CTRL, 8'h00);
		wr(ADDR_COUNT_LO, 8'h57);
		wr(ADDR_CTRL, 8'h10);
		// Slow clock toggles only here, so its divide-by-8 starts from zero
		repeat (8)
		begin
			i_rtc_clk <= 1'h1;
			repeat (4) @(posedge i_clk);
			i_rtc_clk <= 1'h0;
			repeat (4) @(posedge i_clk);
		end
		repeat (6) @(posedge i_clk);
		rdchk(ADDR_RELOAD_LO, 8'h57);
		rdchk(ADDR_CTRL, 8'h90);
		// Two comparator rises 11 cycles apart against a running counter
		wr(ADDR_CTRL, 8'h17);
		repeat (2)
		begin
			first_cap = rd[7:0];
			i_cmp_out <= 1'h1;
			repeat (4) @(posedge i_clk);
			i_cmp_out <= 1'h0;
			repeat (4) @(posedge i_clk);
			apb(1'h0, ADDR_RELOAD_LO, 8'h00);
		end
		check({24'h0, rd[7:0] - first_cap}, 32'hb);
		irqchk(1'h1);
		wr(ADDR_IRQ_EN, 8'h00);
		repeat (2) @(posedge i_clk);
		irqchk(1'h0);
		wr(ADDR_CLK_CTRL, 8'h00);
		wr(ADDR_COUNT_LO, 8'h11);
		wr(ADDR_CTRL, 8'h0e);
		repeat (30) @(posedge i_clk);
		rdchk(ADDR_COUNT_LO, 8'h11);
		// Mid-run reset, then the divide-by-12 source from a known phase
		i_rst_n <= 1'h0;
		repeat (2) @(posedge i_clk);
		i_rst_n <= 1'h1;
		rdchk(ADDR_CTRL, 8'h00);
		rdchk(ADDR_COUNT_LO, 8'h00);
		wr(ADDR_CTRL, 8'h04);
		repeat (120) @(posedge i_clk);
		rdchk(ADDR_COUNT_LO, 8'h0a);
		give_verdict();
	end
endmodule : tb_auto_reload_timer_with_capture
